// file: core/dofs_defines.svh
// constants for the digital output function select block
// assumes apb with 32-bit data and a 250 MHz pclk
//
// Notes on behaviour
// - two relays, open collector, fast output
// - config bit picks pulse or level fast output
// - shared code gives identical terminal states, except virtual bit codes and the fast output in pulse mode
// - code 0 holds terminal inactive
// - code 1 on while running with frequency
// - code 2 on while forward with frequency
// - code 3 on while reverse with frequency
// - code 4 on while jogging with frequency
// - code 5 on while fault present
// - code 9 on when output, reference zero
// - code 10 on at upper limit
// - code 11 on at lower limit
// - code 12 on when powered, unprotected, ready
// - code 13 on while pre-exciting
// - code 14 on for overload pre-alarm
// - code 15 on for underload pre-alarm
// - code 16 signals sequencer stage completion
// - code 17 signals sequencer cycle completion
// - code 23 follows modbus virtual bit
// - codes 24, 25, 34 follow fieldbus bits
// - code 26 on while dc bus established
`ifndef DOFS_DEFINES_SVH
`define DOFS_DEFINES_SVH

// register byte offsets
`define DOFS_OFS_CODE_RLY1 8'h00
`define DOFS_OFS_CODE_RLY2 8'h04
`define DOFS_OFS_CODE_OC 8'h08
`define DOFS_OFS_CODE_FAST 8'h0c
`define DOFS_OFS_FAST_CFG 8'h10
`define DOFS_OFS_VBIT 8'h14
`define DOFS_OFS_STATUS 8'h18

// terminal indices
`define DOFS_T_RLY1 0
`define DOFS_T_RLY2 1
`define DOFS_T_OC 2
`define DOFS_T_FAST 3
`define DOFS_NTERM 4

// reset values
`define DOFS_RST_CODE_RLY1 6'h01
`define DOFS_RST_CODE 6'h00
`define DOFS_RST_HALF_PER 16'h0000
`define DOFS_RST_VBIT 16'h0000

// field positions
`define DOFS_CODE_W 6
`define DOFS_F_PULSE_MODE 0
`define DOFS_F_HALF_PER_LSB 16
`define DOFS_HALF_PER_W 16
`define DOFS_VBIT_W 16
`define DOFS_ST_COND_LSB 8

// virtual bit sources, one nibble each, bit per terminal
`define DOFS_V_MODBUS 0
`define DOFS_V_FIELDBUS 1
`define DOFS_V_ETH 2
`define DOFS_V_ECAT 3
`define DOFS_NVSRC 4

// condition vector positions
`define DOFS_C_RUN 0
`define DOFS_C_FWD 1
`define DOFS_C_REV 2
`define DOFS_C_JOG 3
`define DOFS_C_FAULT 4
`define DOFS_C_ZERO 5
`define DOFS_C_UPPER 6
`define DOFS_C_LOWER 7
`define DOFS_C_READY 8
`define DOFS_C_PREEXC 9
`define DOFS_C_OVL 10
`define DOFS_C_UNL 11
`define DOFS_C_STAGE 12
`define DOFS_C_CYCLE 13
`define DOFS_C_DCBUS 14
`define DOFS_NCOND 15

// timing
`define DOFS_CLK_MHZ 250
`define DOFS_EVT_HOLD_US 1000
`define DOFS_EVT_CNT_W 18

`endif

// file: core/dofs_pkg.sv
// types shared by the digital output function select block
// assumes dofs_defines.svh for widths
`include "dofs_defines.svh"
package dofs_pkg;
   typedef logic [`DOFS_CODE_W-1:0] dofs_code_t;
   typedef enum logic [`DOFS_CODE_W-1:0] {
      DOFS_FN_NONE = 6'h00,
      DOFS_FN_RUN = 6'h01,
      DOFS_FN_FWD = 6'h02,
      DOFS_FN_REV = 6'h03,
      DOFS_FN_JOG = 6'h04,
      DOFS_FN_FAULT = 6'h05,
      DOFS_FN_ZERO = 6'h09,
      DOFS_FN_UPPER = 6'h0a,
      DOFS_FN_LOWER = 6'h0b,
      DOFS_FN_READY = 6'h0c,
      DOFS_FN_PREEXC = 6'h0d,
      DOFS_FN_OVL = 6'h0e,
      DOFS_FN_UNL = 6'h0f,
      DOFS_FN_STAGE = 6'h10,
      DOFS_FN_CYCLE = 6'h11,
      DOFS_FN_MODBUS = 6'h17,
      DOFS_FN_FIELDBUS = 6'h18,
      DOFS_FN_ETH = 6'h19,
      DOFS_FN_DCBUS = 6'h1a,
      DOFS_FN_ECAT = 6'h22
   } dofs_fn_e;
endpackage

// file: core/dofs_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous level inputs from pins
`timescale 1ns/1ps
`include "dofs_defines.svh"
module dofs_sync #(
   parameter int W = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   import dofs_pkg::*;
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } dofs_sync_s;
   dofs_sync_s s;
   dofs_sync_s next_s;

   // first stage feeds only the second
   always_comb begin
      next_s = s;
      next_s.s1 = din;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      for (int i = 0; i < W; i++) begin
         if (s.s2[i] == s.s3[i]) begin
            next_s.q[i] = s.s3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         next_s_reset: s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign dout = s.q;
endmodule // dofs_sync

// file: core/dofs_sel.sv
// per-terminal function mux: selection code to output condition
// assumes conditions already combined on pclk
`timescale 1ns/1ps
`include "dofs_defines.svh"
module dofs_sel (
   input wire dofs_pkg::dofs_code_t code,
   input wire logic [`DOFS_NCOND-1:0] cond,
   input wire logic [`DOFS_NVSRC-1:0] vbit,
   output logic hit
);
   import dofs_pkg::*;
   always_comb begin
      case (dofs_fn_e'(code))
         DOFS_FN_RUN: hit = cond[`DOFS_C_RUN];
         DOFS_FN_FWD: hit = cond[`DOFS_C_FWD];
         DOFS_FN_REV: hit = cond[`DOFS_C_REV];
         DOFS_FN_JOG: hit = cond[`DOFS_C_JOG];
         DOFS_FN_FAULT: hit = cond[`DOFS_C_FAULT];
         DOFS_FN_ZERO: hit = cond[`DOFS_C_ZERO];
         DOFS_FN_UPPER: hit = cond[`DOFS_C_UPPER];
         DOFS_FN_LOWER: hit = cond[`DOFS_C_LOWER];
         DOFS_FN_READY: hit = cond[`DOFS_C_READY];
         DOFS_FN_PREEXC: hit = cond[`DOFS_C_PREEXC];
         DOFS_FN_OVL: hit = cond[`DOFS_C_OVL];
         DOFS_FN_UNL: hit = cond[`DOFS_C_UNL];
         DOFS_FN_STAGE: hit = cond[`DOFS_C_STAGE];
         DOFS_FN_CYCLE: hit = cond[`DOFS_C_CYCLE];
         DOFS_FN_MODBUS: hit = vbit[`DOFS_V_MODBUS];
         DOFS_FN_FIELDBUS: hit = vbit[`DOFS_V_FIELDBUS];
         DOFS_FN_ETH: hit = vbit[`DOFS_V_ETH];
         DOFS_FN_ECAT: hit = vbit[`DOFS_V_ECAT];
         DOFS_FN_DCBUS: hit = cond[`DOFS_C_DCBUS];
         default: hit = 1'b0;
      endcase
   end
endmodule // dofs_sel

// file: core/dofs_top.sv
// digital output function select: apb registers, condition
// building, four terminal muxes, fast pulse generator
// assumes status inputs on pclk except the two pin-level ones
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "dofs_defines.svh"
module dofs_top #(
   parameter int ADDR_W = 8,
   parameter int EVT_HOLD_CYCLES = `DOFS_EVT_HOLD_US * `DOFS_CLK_MHZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic drv_running,
   input wire logic drv_reverse,
   input wire logic drv_jogging,
   input wire logic freq_nonzero,
   input wire logic ref_freq_zero,
   input wire logic drv_fault,
   input wire logic at_upper_limit,
   input wire logic at_lower_limit,
   input wire logic power_ok_pin,
   input wire logic protect_active,
   input wire logic drv_ready,
   input wire logic pre_exciting,
   input wire logic overload_prealarm,
   input wire logic underload_prealarm,
   input wire logic seq_stage_done,
   input wire logic seq_cycle_done,
   input wire logic dc_bus_ok_pin,
   output logic relay_one,
   output logic relay_two,
   output logic open_collector_out,
   output logic fast_pulse_or_level_output
);
   import dofs_pkg::*;

   localparam int CW = `DOFS_EVT_CNT_W;
   localparam int NT = `DOFS_NTERM;
   localparam int HW = `DOFS_HALF_PER_W;
   localparam logic [CW-1:0] HOLD = CW'(EVT_HOLD_CYCLES);

   typedef struct packed {
      logic [NT-1:0][`DOFS_CODE_W-1:0] code;
      logic pulse_mode;
      logic [HW-1:0] half_per;
      logic [`DOFS_VBIT_W-1:0] vbit;
      logic [CW-1:0] stage_cnt;
      logic [CW-1:0] cycle_cnt;
      logic [HW-1:0] pcnt;
      logic plvl;
      logic [NT-1:0] term;
      logic [31:0] rdata;
      logic err;
   } dofs_top_s;

   dofs_top_s s;
   dofs_top_s next_s;
   logic [1:0] pin_sync;
   logic [`DOFS_NCOND-1:0] cond;
   logic [NT-1:0] hit;
   logic setup;
   logic wr_access;

   ////////////////////////////////////////////////////////////////////
   // register decode

   function automatic logic [3:0] reg_idx(input logic [ADDR_W-1:0] a);
      logic [3:0] r;
      r = 4'hf;
      if (a == ADDR_W'(`DOFS_OFS_CODE_RLY1)) begin
         r = 4'h0;
      end else if (a == ADDR_W'(`DOFS_OFS_CODE_RLY2)) begin
         r = 4'h1;
      end else if (a == ADDR_W'(`DOFS_OFS_CODE_OC)) begin
         r = 4'h2;
      end else if (a == ADDR_W'(`DOFS_OFS_CODE_FAST)) begin
         r = 4'h3;
      end else if (a == ADDR_W'(`DOFS_OFS_FAST_CFG)) begin
         r = 4'h4;
      end else if (a == ADDR_W'(`DOFS_OFS_VBIT)) begin
         r = 4'h5;
      end else if (a == ADDR_W'(`DOFS_OFS_STATUS)) begin
         r = 4'h6;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // pin-level inputs and condition vector

   dofs_sync #(
      .W(2)
   ) u_pin_sync (
      .pclk(pclk),
      .presetn(presetn),
      .din({dc_bus_ok_pin, power_ok_pin}),
      .dout(pin_sync)
   );

   always_comb begin
      cond = '0;
      cond[`DOFS_C_RUN] = drv_running & freq_nonzero;
      cond[`DOFS_C_FWD] = drv_running & ~drv_reverse & freq_nonzero;
      cond[`DOFS_C_REV] = drv_running & drv_reverse & freq_nonzero;
      cond[`DOFS_C_JOG] = drv_jogging & freq_nonzero;
      cond[`DOFS_C_FAULT] = drv_fault;
      cond[`DOFS_C_ZERO] = ~freq_nonzero & ref_freq_zero;
      cond[`DOFS_C_UPPER] = at_upper_limit;
      cond[`DOFS_C_LOWER] = at_lower_limit;
      cond[`DOFS_C_READY] = pin_sync[0] & ~protect_active & drv_ready;
      cond[`DOFS_C_PREEXC] = pre_exciting;
      cond[`DOFS_C_OVL] = overload_prealarm;
      cond[`DOFS_C_UNL] = underload_prealarm;
      cond[`DOFS_C_STAGE] = (s.stage_cnt != '0);
      cond[`DOFS_C_CYCLE] = (s.cycle_cnt != '0);
      cond[`DOFS_C_DCBUS] = pin_sync[1];
   end

   ////////////////////////////////////////////////////////////////////
   // one mux per terminal

   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_term
         dofs_sel u_sel (
            .code(s.code[g]),
            .cond(cond),
            .vbit({s.vbit[`DOFS_V_ECAT*NT+g], s.vbit[`DOFS_V_ETH*NT+g],
                   s.vbit[`DOFS_V_FIELDBUS*NT+g], s.vbit[`DOFS_V_MODBUS*NT+g]}),
            .hit(hit[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // next state

   assign setup = psel & ~penable;
   assign wr_access = psel & penable & pwrite;

   always_comb begin
      next_s = s;
      // read data and error latched in setup, shown in access
      if (setup) begin
         next_s.rdata = '0;
         next_s.err = 1'b0;
         case (reg_idx(paddr))
            4'h0, 4'h1, 4'h2, 4'h3: begin
               next_s.rdata[`DOFS_CODE_W-1:0] = s.code[reg_idx(paddr)];
            end
            4'h4: begin
               next_s.rdata[`DOFS_F_PULSE_MODE] = s.pulse_mode;
               next_s.rdata[`DOFS_F_HALF_PER_LSB +: HW] = s.half_per;
            end
            4'h5: begin
               next_s.rdata[`DOFS_VBIT_W-1:0] = s.vbit;
            end
            4'h6: begin
               next_s.rdata[NT-1:0] = s.term;
               next_s.rdata[`DOFS_ST_COND_LSB +: `DOFS_NCOND] = cond;
            end
            default: begin
               next_s.err = 1'b1;
            end
         endcase
      end
      if (wr_access) begin
         case (reg_idx(paddr))
            4'h0, 4'h1, 4'h2, 4'h3: begin
               next_s.code[reg_idx(paddr)] = pwdata[`DOFS_CODE_W-1:0];
            end
            4'h4: begin
               next_s.pulse_mode = pwdata[`DOFS_F_PULSE_MODE];
               next_s.half_per = pwdata[`DOFS_F_HALF_PER_LSB +: HW];
            end
            4'h5: begin
               next_s.vbit = pwdata[`DOFS_VBIT_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // sequencer events stretched so a relay can follow; new event reloads
      if (seq_stage_done) begin
         next_s.stage_cnt = HOLD;
      end else if (s.stage_cnt != '0) begin
         next_s.stage_cnt = s.stage_cnt - CW'(1);
      end
      if (seq_cycle_done) begin
         next_s.cycle_cnt = HOLD;
      end else if (s.cycle_cnt != '0) begin
         next_s.cycle_cnt = s.cycle_cnt - CW'(1);
      end
      // fast output pulse train while its function is active
      if (s.pulse_mode & hit[`DOFS_T_FAST]) begin
         if (s.pcnt == '0) begin
            next_s.pcnt = s.half_per;
            next_s.plvl = ~s.plvl;
         end else begin
            next_s.pcnt = s.pcnt - HW'(1);
         end
      end else begin
         next_s.pcnt = '0;
         next_s.plvl = 1'b0;
      end
      next_s.term = hit;
      if (s.pulse_mode) begin
         next_s.term[`DOFS_T_FAST] = hit[`DOFS_T_FAST] & next_s.plvl;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.code[`DOFS_T_RLY1] <= `DOFS_RST_CODE_RLY1;
         s.half_per <= `DOFS_RST_HALF_PER;
         s.vbit <= `DOFS_RST_VBIT;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign pready = psel & penable;
   assign pslverr = pready & s.err;
   assign prdata = s.rdata;
   assign relay_one = s.term[`DOFS_T_RLY1];
   assign relay_two = s.term[`DOFS_T_RLY2];
   assign open_collector_out = s.term[`DOFS_T_OC];
   assign fast_pulse_or_level_output = s.term[`DOFS_T_FAST];

   ////////////////////////////////////////////////////////////////////
   // checks

   sequence s_stage_seen;
      seq_stage_done && s.code[`DOFS_T_RLY1] == DOFS_FN_STAGE
      ##1 s.code[`DOFS_T_RLY1] == DOFS_FN_STAGE;
   endsequence

   sequence s_pulse_running;
      s.pulse_mode && hit[`DOFS_T_FAST] && s.half_per == '0;
   endsequence

   property p_none_idle;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_RLY2] == DOFS_FN_NONE |=> !relay_two;
   endproperty
   a_none_idle: assert property (p_none_idle)
      else $error("code 0 terminal not inactive");

   property p_run;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_RLY1] == DOFS_FN_RUN
         |=> relay_one == $past(drv_running & freq_nonzero);
   endproperty
   a_run: assert property (p_run)
      else $error("running output mismatch");

   property p_fwd;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_OC] == DOFS_FN_FWD
         |=> open_collector_out == $past(drv_running & ~drv_reverse & freq_nonzero);
   endproperty
   a_fwd: assert property (p_fwd)
      else $error("forward output mismatch");

   property p_rev;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_FAST] == DOFS_FN_REV && !s.pulse_mode
         |=> fast_pulse_or_level_output == $past(drv_running & drv_reverse & freq_nonzero);
   endproperty
   a_rev: assert property (p_rev)
      else $error("reverse output mismatch");

   property p_fault;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_RLY2] == DOFS_FN_FAULT && drv_fault |=> relay_two;
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault not shown");

   property p_zero;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_OC] == DOFS_FN_ZERO && freq_nonzero |=> !open_collector_out;
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero speed on with frequency");

   // virtual bit codes follow a bit of each terminal's own, so they may differ
   property p_same_code;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_RLY1] == s.code[`DOFS_T_OC]
         && !(s.code[`DOFS_T_RLY1] inside {DOFS_FN_MODBUS, DOFS_FN_FIELDBUS,
                                           DOFS_FN_ETH, DOFS_FN_ECAT})
         |=> relay_one == open_collector_out;
   endproperty
   a_same_code: assert property (p_same_code)
      else $error("shared code terminals differ");

   property p_stage;
      @(posedge pclk) disable iff (!presetn)
         s_stage_seen |=> relay_one;
   endproperty
   a_stage: assert property (p_stage)
      else $error("stage completion not signalled");

   property p_modbus;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_RLY2] == DOFS_FN_MODBUS
         |=> relay_two == $past(s.vbit[`DOFS_V_MODBUS*NT+`DOFS_T_RLY2]);
   endproperty
   a_modbus: assert property (p_modbus)
      else $error("modbus virtual bit not followed");

   property p_reserved;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_OC] == 6'h23 |=> !open_collector_out;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved code drove terminal");

   property p_pulse_toggle;
      @(posedge pclk) disable iff (!presetn)
         s_pulse_running [*3] |=> fast_pulse_or_level_output != $past(fast_pulse_or_level_output);
   endproperty
   a_pulse_toggle: assert property (p_pulse_toggle)
      else $error("fast pulse train not toggling");

   property p_dcbus;
      @(posedge pclk) disable iff (!presetn)
         s.code[`DOFS_T_RLY2] == DOFS_FN_DCBUS |=> relay_two == $past(pin_sync[1]);
   endproperty
   a_dcbus: assert property (p_dcbus)
      else $error("dc bus output mismatch");
endmodule // dofs_top

// file: verif/dofs_load_model.sv
// field side model: the four terminals driving relay coils and loads
// assumes terminals are registered on pclk, active high
`timescale 1ns/1ps
module dofs_load_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic relay_one,
   input wire logic relay_two,
   input wire logic open_collector_out,
   input wire logic fast_pulse_or_level_output,
   output logic [3:0] energised,
   output logic [15:0] fast_hi_len
);
   logic [15:0] hi_cnt;
   ////////////////////////////////////////////////////////////////
   // coil state seen by the loads, one bit per terminal
   assign energised = {fast_pulse_or_level_output, open_collector_out, relay_two, relay_one};
   // width of the last completed high pulse on the fast terminal
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt <= 16'h0000;
         fast_hi_len <= 16'h0000;
      end else if (fast_pulse_or_level_output) begin
         hi_cnt <= hi_cnt + 16'h0001;
      end else begin
         if (hi_cnt != 16'h0000) fast_hi_len <= hi_cnt;
         hi_cnt <= 16'h0000;
      end
   end
endmodule // dofs_load_model

// file: verif/dofs_tb_top.sv
// self-checking bench for the output function select block
// assumes apb master here, load model on the terminals
`timescale 1ns/1ps
module dofs_tb_top;
   import dofs_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [16:0] st;
   logic [3:0] seen;
   logic [3:0] term;
   localparam int HOLD_CYC = 8;
   logic [15:0] hi_len;
   logic err;
   int failures, tests_run, cycles;
   ////////////////////////////////////////////////////////////////
   dofs_top #(.ADDR_W(8), .EVT_HOLD_CYCLES(HOLD_CYC)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .drv_running(st[0]), .drv_reverse(st[1]), .drv_jogging(st[2]),
      .freq_nonzero(st[3]), .ref_freq_zero(st[4]), .drv_fault(st[5]),
      .at_upper_limit(st[6]), .at_lower_limit(st[7]), .power_ok_pin(st[8]),
      .protect_active(st[9]), .drv_ready(st[10]), .pre_exciting(st[11]),
      .overload_prealarm(st[12]), .underload_prealarm(st[13]),
      .seq_stage_done(st[14]), .seq_cycle_done(st[15]), .dc_bus_ok_pin(st[16]),
      .relay_one(term[0]), .relay_two(term[1]), .open_collector_out(term[2]),
      .fast_pulse_or_level_output(term[3])
   );
   dofs_load_model i_load (
      .pclk(pclk), .presetn(presetn), .relay_one(term[0]),
      .relay_two(term[1]), .open_collector_out(term[2]),
      .fast_pulse_or_level_output(term[3]),
      .energised(seen), .fast_hi_len(hi_len)
   );
   ////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic codes(input logic [5:0] c);
      for (int t = 0; t < 4; t++) apb(1'b1, 8'(4 * t), {26'h0, c});
   endtask
   // drive status, let the pin synchronisers settle, then look
   task automatic drive(input logic [16:0] v, input logic [3:0] exp, input string what);
      @(posedge pclk);
      st <= v;
      repeat (6) @(posedge pclk);
      #1;
      check(what, {28'h0, seen}, {28'h0, exp});
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      drive(17'h00009, 4'h1, "reset default running");
      apb(1'b0, 8'h18, 32'h0);
      check("status terminals and conditions", rd, 32'h00000301);
      apb(1'b0, 8'h00, 32'h0);
      check("relay one code reset", rd, 32'h00000001);
      apb(1'b0, 8'h0c, 32'h0);
      check("fast code reset", rd, 32'h00000000);
      apb(1'b1, 8'h04, 32'hffffffff);
      apb(1'b0, 8'h04, 32'h0);
      check("relay two code width", rd, 32'h0000003f);
      apb(1'b0, 8'h1c, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_functions();
      logic [5:0] c [13] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h09, 6'h0a,
                             6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h1a};
      logic [16:0] on [13] = '{17'h9, 17'h9, 17'hb, 17'hc, 17'h20, 17'h10, 17'h40,
                               17'h80, 17'h500, 17'h800, 17'h1000, 17'h2000, 17'h10000};
      logic [16:0] off [13] = '{17'h1, 17'hb, 17'h9, 17'h4, 17'h0, 17'h18, 17'h0,
                                17'h0, 17'h700, 17'h0, 17'h0, 17'h0, 17'h0};
      for (int i = 0; i < 13; i++) begin
         codes(c[i]);
         drive(on[i], 4'hf, "function on");
         drive(off[i], 4'h0, "function off");
      end
      $display("test functions done");
   endtask
   task automatic t_events();
      for (int k = 0; k < 2; k++) begin
         codes(k ? 6'h11 : 6'h10);
         @(posedge pclk);
         st <= k ? 17'h08000 : 17'h04000;
         @(posedge pclk);
         st <= 17'h0;
         // last edge of the stretched event, then the first edge after it
         repeat (HOLD_CYC) @(posedge pclk);
         #1;
         check("sequencer event held", {28'h0, seen}, 32'hf);
         @(posedge pclk);
         #1;
         check("sequencer event over", {28'h0, seen}, 32'h0);
      end
      $display("test events done");
   endtask
   task automatic t_reserved();
      logic [5:0] c [9] = '{6'h00, 6'h06, 6'h07, 6'h08, 6'h12, 6'h15, 6'h1b, 6'h23, 6'h3f};
      apb(1'b1, 8'h14, 32'h0000ffff);
      for (int i = 0; i < 9; i++) begin
         codes(c[i]);
         drive(17'h1fdff, 4'h0, "idle code");
      end
      $display("test reserved done");
   endtask
   task automatic t_vbits();
      logic [5:0] c [4] = '{6'h17, 6'h18, 6'h19, 6'h22};
      @(posedge pclk);
      st <= 17'h0;
      for (int s = 0; s < 4; s++) begin
         codes(c[s]);
         apb(1'b1, 8'h14, 32'(4'h5) << (4 * s));
         drive(17'h0, 4'h5, "virtual bits a");
         apb(1'b1, 8'h14, (32'(4'ha) << (4 * s)) | 32'(~(16'hf << (4 * s))));
         drive(17'h0, 4'ha, "virtual bits b");
      end
      apb(1'b1, 8'h14, 32'h0);
      $display("test virtual bits done");
   endtask
   task automatic t_pulse();
      codes(6'h05);
      apb(1'b1, 8'h10, 32'h00020001);
      apb(1'b0, 8'h10, 32'h0);
      check("fast config readback", rd, 32'h00020001);
      drive(17'h20, 4'h7, "pulse mode relays");
      repeat (30) @(posedge pclk);
      #1;
      check("pulse high width", {16'h0, hi_len}, 32'h3);
      apb(1'b1, 8'h10, 32'h0);
      drive(17'h20, 4'hf, "level mode");
      drive(17'h0, 4'h0, "level mode off");
      // half period zero: the fast output toggles on every edge
      apb(1'b1, 8'h10, 32'h00000001);
      drive(17'h20, 4'h7, "fast toggle relays");
      repeat (10) @(posedge pclk);
      #1;
      check("toggle high width", {16'h0, hi_len}, 32'h1);
      $display("test pulse done");
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      st = 17'h0;
      failures = 0;
      tests_run = 0;
      cycles = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_functions();
      t_events();
      t_reserved();
      t_vbits();
      t_pulse();
      conclude();
   end
endmodule // dofs_tb_top
